// ### core/pc_compatible_uart_rx_status.sv
`timescale 1ns/10ps
// Operation
// - Overrun, framing, break, parity flags stay set until a line status read.
// - Parity error is updated at the stop bit with the other flags.
// - Modem status reads with bits 4, 5 and 7 always set.
// - Receiver keeps accepting characters after a break without a status read.
// - Receive buffer loads only when the stop bit has been received.
// - Enabling parity never corrupts the next character or its flags.
// - Identification shows code 110 only while a line status condition pends.
// - Identification bit 0 is set with nothing pending, clear otherwise.
// - Interrupt output is a level held while any source pends.
// - Back-to-back line status reads never lose an error event.
// - Each word starts with a spacing start bit of exactly one bit time.
// - Each word ends with at least one marking stop bit.
// - Idle transmit line stays at marking level.
// - Word lengths five to eight bits, optional parity generation and checking.
// - Baud generator reaches at least 115.2k baud.
// - Line status bits: ready, overrun, parity, framing, break, holding empty, empty.
// - Source codes 11 line status, 10 data available, 01 holding empty.
module pc_compatible_uart_rx_status (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Serial line
  input  wire logic        RXD,
  output logic             TXD,
  // Interrupt
  output logic             INTR
);
  import uart_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        pend;
    logic        wr;
    logic        ok;
    logic [2:0]  idx;
    logic [31:0] hrdata;
    logic [15:0] divisor;
    logic [3:0]  ien;
    logic [7:0]  lctl;
    logic        int_en;
    logic [7:0]  scratch;
    logic [7:0]  thr;
    logic        thr_full;
    logic        thre_pend;
    logic [7:0]  rx_buf;
    logic        data_ready;
    logic        overrun;
    logic        par_err;
    logic        frm_err;
    logic        brk;
    logic [15:0] baud_cnt;
    logic        tick;
    logic        intr;
  } top_t;

  top_t       s_reg;
  top_t       s_next;

  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_par;
  logic       rx_frm;
  logic       rx_brk;
  logic       tx_take;
  logic       tx_busy;
  logic       tx_line;

  logic       accept;
  logic       sel_div;
  logic       rd;
  logic       wrt;
  logic       rd_buf;
  logic       rd_lstat;
  logic       rd_iid;
  logic       wr_thr;
  logic       src_rls;
  logic       src_rda;
  logic       src_thre;
  logic       any_src;
  logic [1:0] src_code;
  logic [7:0] iid_val;
  logic [7:0] lstat_val;
  logic [7:0] rdata;
  line_cfg_t  cfg;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign accept   = HSEL && HTRANS[1] && HREADY;
  assign sel_div  = s_reg.lctl[LCTL_SEL_DIV];
  assign rd       = s_reg.pend && !s_reg.wr && s_reg.ok;
  assign wrt      = s_reg.pend && s_reg.wr && s_reg.ok;
  assign rd_buf   = rd && (s_reg.idx == IDX_DATA) && !sel_div;
  assign rd_lstat = rd && (s_reg.idx == IDX_LSTAT);
  assign rd_iid   = rd && (s_reg.idx == IDX_IID);
  assign wr_thr   = wrt && (s_reg.idx == IDX_DATA) && !sel_div;
  assign cfg      = line_cfg_t'(s_reg.lctl[5:0]);

  // ----------------------------------------------------------------
  // Interrupt identification
  // ----------------------------------------------------------------
  // Decoded straight from the live flags, so no stale or false code
  assign src_rls  = s_reg.ien[IEN_RLS] && (s_reg.overrun || s_reg.par_err || s_reg.frm_err || s_reg.brk);
  assign src_rda  = s_reg.ien[IEN_RDA] && s_reg.data_ready;
  assign src_thre = s_reg.ien[IEN_THRE] && s_reg.thre_pend;
  assign any_src  = src_rls || src_rda || src_thre;

  always_comb begin
    if (src_rls) begin
      src_code = SRC_RLS;
    end else if (src_rda) begin
      src_code = SRC_RDA;
    end else if (src_thre) begin
      src_code = SRC_THRE;
    end else begin
      src_code = SRC_NONE;
    end
  end

  assign iid_val = {5'h00, src_code, ~any_src};

  // ----------------------------------------------------------------
  // Line status
  // ----------------------------------------------------------------
  assign lstat_val = {1'b0,
                      !s_reg.thr_full && !tx_busy,
                      !s_reg.thr_full,
                      s_reg.brk,
                      s_reg.frm_err,
                      s_reg.par_err,
                      s_reg.overrun,
                      s_reg.data_ready};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (s_reg.idx)
      IDX_DATA:    rdata = sel_div ? s_reg.divisor[7:0] : s_reg.rx_buf;
      IDX_IEN:     rdata = sel_div ? s_reg.divisor[15:8] : {4'h0, s_reg.ien};
      IDX_IID:     rdata = iid_val;
      IDX_LCTL:    rdata = s_reg.lctl;
      IDX_MCTL:    rdata = {4'h0, s_reg.int_en, 3'h0};
      IDX_LSTAT:   rdata = lstat_val;
      IDX_MSTAT:   rdata = MSTAT_VALUE;
      IDX_SCRATCH: rdata = s_reg.scratch;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // Bus: one wait state, read data and side effects on that edge
    s_next.pend = 1'b0;
    if (accept) begin
      s_next.pend = 1'b1;
      s_next.wr   = HWRITE;
      s_next.idx  = HADDR[ADDR_MSB:ADDR_LSB];
      s_next.ok   = (HADDR[31:ADDR_MSB+1] == 27'h0000000) && (HSIZE == HSIZE_WORD);
    end
    if (s_reg.pend && !s_reg.wr) begin
      s_next.hrdata = s_reg.ok ? {24'h000000, rdata} : 32'h00000000;
    end

    // Register writes
    if (wrt) begin
      unique case (s_reg.idx)
        IDX_DATA: begin
          if (sel_div) begin
            s_next.divisor[7:0] = HWDATA[7:0];
          end else begin
            s_next.thr = HWDATA[7:0];
          end
        end
        IDX_IEN: begin
          if (sel_div) begin
            s_next.divisor[15:8] = HWDATA[7:0];
          end else begin
            s_next.ien = HWDATA[3:0];
          end
        end
        IDX_LCTL:    s_next.lctl = HWDATA[7:0];
        IDX_MCTL:    s_next.int_en = HWDATA[MCTL_INT_EN];
        IDX_SCRATCH: s_next.scratch = HWDATA[7:0];
        default: begin
        end
      endcase
    end

    // Baud tick at sixteen times the bit rate
    if (s_reg.divisor == 16'h0000) begin
      s_next.baud_cnt = 16'h0000;
      s_next.tick     = 1'b0;
    end else if (s_reg.baud_cnt >= (s_reg.divisor - 16'h0001)) begin
      s_next.baud_cnt = 16'h0000;
      s_next.tick     = 1'b1;
    end else begin
      s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;
      s_next.tick     = 1'b0;
    end

    // Holding register
    if (wr_thr) begin
      s_next.thr_full = 1'b1;
    end else if (tx_take) begin
      s_next.thr_full = 1'b0;
    end
    s_next.thre_pend = (tx_take && !wr_thr) ||
                       (s_reg.thre_pend && !(wr_thr || (rd_iid && src_code == SRC_THRE)));

    // Receive buffer and sticky error flags, a new event wins over the clear
    if (rx_done) begin
      s_next.rx_buf = rx_data;
    end
    s_next.data_ready = rx_done || (s_reg.data_ready && !rd_buf);
    s_next.overrun    = (rx_done && s_reg.data_ready && !rd_buf) || (s_reg.overrun && !rd_lstat);
    s_next.par_err    = (rx_done && rx_par) || (s_reg.par_err && !rd_lstat);
    s_next.frm_err    = (rx_done && rx_frm) || (s_reg.frm_err && !rd_lstat);
    s_next.brk        = (rx_done && rx_brk) || (s_reg.brk && !rd_lstat);

    // Level interrupt, no fresh edge per added source
    s_next.intr = any_src && s_reg.int_en;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg           <= '0;
      s_reg.divisor   <= DIV_RST;
      s_reg.ien       <= IEN_RST;
      s_reg.lctl      <= LCTL_RST;
      s_reg.scratch   <= SCRATCH_RST;
      s_reg.thre_pend <= THRE_PEND_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Receiver and transmitter
  // ----------------------------------------------------------------
  uart_rx u_rx (
    .clk         (CLOCK),
    .arst_n      (ARST_N),
    .tick        (s_reg.tick),
    .rxd         (RXD),
    .cfg         (cfg),
    .done        (rx_done),
    .data        (rx_data),
    .parity_err  (rx_par),
    .framing_err (rx_frm),
    .break_det   (rx_brk)
  );

  uart_tx u_tx (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .tick   (s_reg.tick),
    .go     (s_reg.thr_full),
    .data   (s_reg.thr),
    .cfg    (cfg),
    .brk    (s_reg.lctl[LCTL_BREAK]),
    .take   (tx_take),
    .busy   (tx_busy),
    .txd    (tx_line)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA    = s_reg.hrdata;
  assign HREADYOUT = !s_reg.pend;
  assign HRESP     = 1'b0;
  assign TXD       = tx_line;
  assign INTR      = s_reg.intr;

endmodule

// ### include/uart_pkg.sv
package uart_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned MAX_BAUD   = 115_200;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [15:0] DIV_RST    = 16'h0041;
  localparam logic [3:0]  TICK_MID   = 4'h7;
  localparam logic [3:0]  TICK_LAST  = 4'hf;
  localparam logic [4:0]  STOP_ONE   = 5'h0f;
  localparam logic [4:0]  STOP_HALF  = 5'h17;
  localparam logic [4:0]  STOP_TWO   = 5'h1f;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_DATA    = 3'h0;
  localparam logic [2:0] IDX_IEN     = 3'h1;
  localparam logic [2:0] IDX_IID     = 3'h2;
  localparam logic [2:0] IDX_LCTL    = 3'h3;
  localparam logic [2:0] IDX_MCTL    = 3'h4;
  localparam logic [2:0] IDX_LSTAT   = 3'h5;
  localparam logic [2:0] IDX_MSTAT   = 3'h6;
  localparam logic [2:0] IDX_SCRATCH = 3'h7;
  localparam int         ADDR_LSB    = 2;
  localparam int         ADDR_MSB    = 4;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LCTL_SEL_DIV = 7;
  localparam int LCTL_BREAK   = 6;
  localparam int IEN_RDA      = 0;
  localparam int IEN_THRE     = 1;
  localparam int IEN_RLS      = 2;
  localparam int MCTL_INT_EN  = 3;

  localparam logic [1:0] SRC_RLS  = 2'h3;
  localparam logic [1:0] SRC_RDA  = 2'h2;
  localparam logic [1:0] SRC_THRE = 2'h1;
  localparam logic [1:0] SRC_NONE = 2'h0;

  // Carrier detect, data set ready, clear to send
  localparam logic [7:0] MSTAT_VALUE = 8'hb0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCTL_RST      = 8'h00;
  localparam logic [3:0] IEN_RST       = 4'h0;
  localparam logic [7:0] SCRATCH_RST   = 8'h00;
  localparam logic       THRE_PEND_RST = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       stick;
    logic       even;
    logic       par_en;
    logic       stop2;
    logic [1:0] wlen;
  } line_cfg_t;

  typedef enum logic [5:0] {
    RX_IDLE   = 6'h01,
    RX_START  = 6'h02,
    RX_DATA   = 6'h04,
    RX_PARITY = 6'h08,
    RX_STOP   = 6'h10,
    RX_MARK   = 6'h20
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'h01,
    TX_START  = 5'h02,
    TX_DATA   = 5'h04,
    TX_PARITY = 5'h08,
    TX_STOP   = 5'h10
  } tx_state_t;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  function automatic logic [2:0] last_bit(input logic [1:0] wlen);
    return 3'(3'h4 + {1'b0, wlen});
  endfunction

  function automatic logic parity_bit(input logic [7:0] d, input line_cfg_t c);
    logic [7:0] m;
    logic       x;
    m = 8'hff >> (2'h3 - c.wlen);
    x = ^(d & m);
    if (c.stick) begin
      return ~c.even;
    end
    return c.even ? x : ~x;
  endfunction

endpackage

// ### core/uart_rx.sv
`timescale 1ns/10ps
module uart_rx (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Sampling
  input  wire logic                tick,
  input  wire logic                rxd,
  input  wire uart_pkg::line_cfg_t cfg,
  // Received word
  output logic                     done,
  output logic [7:0]               data,
  output logic                     parity_err,
  output logic                     framing_err,
  output logic                     break_det
);
  import uart_pkg::*;

  typedef struct packed {
    rx_state_t  st;
    logic [3:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    line_cfg_t  cfg;
    logic       par_in;
    logic       done;
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
    logic       brk;
  } rx_t;

  rx_t r_reg;
  rx_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    unique case (r_reg.st)
      RX_IDLE: begin
        if (!rxd) begin
          r_next.st  = RX_START;
          r_next.cnt = 4'h0;
          r_next.cfg = cfg;
        end
      end
      RX_START: begin
        if (tick) begin
          if (r_reg.cnt == TICK_MID) begin
            r_next.cnt     = 4'h0;
            r_next.bit_idx = 3'h0;
            r_next.shift   = 8'h00;
            r_next.st      = rxd ? RX_IDLE : RX_DATA;
          end else begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == TICK_LAST) begin
            r_next.shift[r_reg.bit_idx] = rxd;
            if (r_reg.bit_idx == last_bit(r_reg.cfg.wlen)) begin
              r_next.st = r_reg.cfg.par_en ? RX_PARITY : RX_STOP;
            end else begin
              r_next.bit_idx = r_reg.bit_idx + 3'h1;
            end
          end
        end
      end
      RX_PARITY: begin
        if (tick) begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == TICK_LAST) begin
            r_next.par_in = rxd;
            r_next.st     = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == TICK_LAST) begin
            r_next.done    = 1'b1;
            r_next.data    = r_reg.shift;
            r_next.par_err = r_reg.cfg.par_en && (r_reg.par_in != parity_bit(r_reg.shift, r_reg.cfg));
            r_next.frm_err = !rxd;
            r_next.brk     = !rxd && (r_reg.shift == 8'h00) && !(r_reg.cfg.par_en && r_reg.par_in);
            r_next.st      = rxd ? RX_IDLE : RX_MARK;
          end
        end
      end
      RX_MARK: begin
        // Wait out a held break, then hunt again without software help
        if (rxd) begin
          r_next.st = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg    <= '0;
      r_reg.st <= RX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done        = r_reg.done;
  assign data        = r_reg.data;
  assign parity_err  = r_reg.par_err;
  assign framing_err = r_reg.frm_err;
  assign break_det   = r_reg.brk;

endmodule

// ### core/uart_tx.sv
`timescale 1ns/10ps
module uart_tx (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Word source
  input  wire logic                tick,
  input  wire logic                go,
  input  wire logic [7:0]          data,
  input  wire uart_pkg::line_cfg_t cfg,
  input  wire logic                brk,
  // Status and line
  output logic                     take,
  output logic                     busy,
  output logic                     txd
);
  import uart_pkg::*;

  typedef struct packed {
    tx_state_t  st;
    logic [4:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    line_cfg_t  cfg;
    logic       take;
    logic       bit_out;
    logic       line;
  } tx_t;

  tx_t        t_reg;
  tx_t        t_next;
  logic       launch;
  logic [4:0] stop_last;
  logic [2:0] nb;

  assign nb        = t_reg.bit_idx + 3'h1;
  assign stop_last = !t_reg.cfg.stop2 ? STOP_ONE : ((t_reg.cfg.wlen == 2'h0) ? STOP_HALF : STOP_TWO);

  always_comb begin
    t_next      = t_reg;
    t_next.take = 1'b0;
    launch      = 1'b0;
    unique case (t_reg.st)
      TX_IDLE: begin
        t_next.bit_out = 1'b1;
        launch         = go && tick;
      end
      TX_START: begin
        if (tick) begin
          t_next.cnt = t_reg.cnt + 5'h01;
          if (t_reg.cnt[3:0] == TICK_LAST) begin
            t_next.cnt     = 5'h00;
            t_next.bit_idx = 3'h0;
            t_next.bit_out = t_reg.shift[0];
            t_next.st      = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          t_next.cnt = t_reg.cnt + 5'h01;
          if (t_reg.cnt[3:0] == TICK_LAST) begin
            t_next.cnt = 5'h00;
            if (t_reg.bit_idx == last_bit(t_reg.cfg.wlen)) begin
              t_next.st      = t_reg.cfg.par_en ? TX_PARITY : TX_STOP;
              t_next.bit_out = t_reg.cfg.par_en ? parity_bit(t_reg.shift, t_reg.cfg) : 1'b1;
            end else begin
              t_next.bit_idx = nb;
              t_next.bit_out = t_reg.shift[nb];
            end
          end
        end
      end
      TX_PARITY: begin
        if (tick) begin
          t_next.cnt = t_reg.cnt + 5'h01;
          if (t_reg.cnt[3:0] == TICK_LAST) begin
            t_next.cnt     = 5'h00;
            t_next.bit_out = 1'b1;
            t_next.st      = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          t_next.cnt = t_reg.cnt + 5'h01;
          if (t_reg.cnt == stop_last) begin
            t_next.st = TX_IDLE;
            launch    = go;
          end
        end
      end
    endcase
    if (launch) begin
      t_next.take    = 1'b1;
      t_next.shift   = data;
      t_next.cfg     = cfg;
      t_next.cnt     = 5'h00;
      t_next.bit_out = 1'b0;
      t_next.st      = TX_START;
    end
    t_next.line = t_next.bit_out & ~brk;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t_reg         <= '0;
      t_reg.st      <= TX_IDLE;
      t_reg.bit_out <= 1'b1;
      t_reg.line    <= 1'b1;
    end else begin
      t_reg <= t_next;
    end
  end

  assign take = t_reg.take;
  assign busy = (t_reg.st != TX_IDLE);
  assign txd  = t_reg.line;

endmodule

// ### tb/uart_assertions.sv
`timescale 1ns/10ps
module uart_assertions (
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        TXD,
  input wire logic        INTR
);
  // ----
  // Bus and line checks
  // ----
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  logic take;
  logic rd;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign rd   = take && !HWRITE;
  sequence done_s;
    ##1 !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_one_wait: assert property (take |-> done_s)
    else $error("wait state count wrong");
  a_resp_okay: assert property (!HRESP)
    else $error("response not okay");
  a_mstat_fixed: assert property (rd && HADDR == 32'h18 |=> ##1 HRDATA == 32'hb0)
    else $error("modem status wrong");
  a_iid_pend: assert property (rd && HADDR == 32'h08 |=> ##1 (INTR -> !HRDATA[0]))
    else $error("pending bit wrong");
  a_lstat_top: assert property (rd && HADDR == 32'h14 |=> ##1 !HRDATA[7])
    else $error("status bit 7 set");
  a_tx_idle: assert property (rd && HADDR == 32'h14 |=> ##1 (HRDATA[6] -> TXD))
    else $error("idle line not marking");
  a_start_len: assert property ($fell(TXD) |-> ##31 !TXD)
    else $error("start bit too short");
  a_intr_level: assert property ($fell(INTR) |-> !$past(HREADYOUT, 2))
    else $error("interrupt dropped without access");
  a_rd_upper: assert property (rd |=> ##1 HRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind pc_compatible_uart_rx_status uart_assertions chk (.*);

// ### tb/uart_remote.sv
`timescale 1ns/10ps
module uart_remote (
  input  wire logic CLOCK,
  input  wire logic TXD,
  output logic      RXD
);
  // ----
  // Remote serial device, divisor 2
  // ----
  localparam int BIT = 32;
  initial RXD = 1'b1;
  task automatic hold;
    repeat (BIT) @(posedge CLOCK);
  endtask
  task automatic send(input logic [7:0] d, input logic p, input logic stop);
    @(posedge CLOCK);
    RXD <= 1'b0;
    hold();
    for (int i = 0; i < 8; i++) begin
      RXD <= d[i];
      hold();
    end
    RXD <= p;
    hold();
    RXD <= stop;
    hold();
    RXD <= 1'b1;
    hold();
  endtask
  task automatic recv(input int n, output logic [7:0] d, output logic stop);
    d = 8'h00;
    @(negedge TXD);
    repeat (BIT / 2) @(posedge CLOCK);
    for (int i = 0; i < n; i++) begin
      hold();
      d[i] = TXD;
    end
    hold();
    stop = TXD;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import uart_pkg::*;
  logic        CLOCK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        HSEL = 1'b1;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = HSIZE_WORD;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        RXD;
  logic        TXD;
  logic        INTR;
  wire         HREADY = HREADYOUT;
  int          errors = 0;
  int          total_checks = 0;
  logic [31:0] q;
  logic [7:0]  b;
  logic        s;
  pc_compatible_uart_rx_status dut (.*);
  uart_remote remote (.CLOCK(CLOCK), .TXD(TXD), .RXD(RXD));
  initial forever #50 CLOCK = ~CLOCK;
  // ----
  // Helpers
  // ----
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic r;
    @(posedge CLOCK);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do begin
      @(negedge CLOCK);
      r = HREADY;
      @(posedge CLOCK);
    end while (r !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do begin
      @(negedge CLOCK);
      r = HREADY;
      q = HRDATA;
      @(posedge CLOCK);
    end while (r !== 1'b1);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h0);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk_intr(input logic e);
    @(negedge CLOCK);
    chk("intr", {31'h0, INTR}, {31'h0, e});
  endtask
  task end_sim;
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    rd("lstat", 8'h14, 32'h60);
    rd("mstat", 8'h18, 32'hb0);
    rd("iid", 8'h08, 32'h01);
    rd("unmapped", 8'h20, 32'h0);
    wr(8'h0c, 8'h80);
    wr(8'h00, 8'h02);
    wr(8'h04, 8'h00);
    rd("div lo", 8'h00, 32'h02);
    wr(8'h0c, 8'h1b);
    wr(8'h10, 8'h08);
    wr(8'h1c, 8'h5e);
    rd("scratch", 8'h1c, 32'h5e);
  endtask
  task t_parity_on;
    remote.send(8'ha5, 1'b0, 1'b1);
    rd("lstat", 8'h14, 32'h61);
    rd("data", 8'h00, 32'ha5);
  endtask
  task t_sticky;
    remote.send(8'h3c, 1'b1, 1'b1);
    remote.send(8'h11, 1'b0, 1'b1);
    rd("lstat", 8'h14, 32'h67);
    rd("lstat", 8'h14, 32'h61);
    rd("data", 8'h00, 32'h11);
  endtask
  task t_irq;
    wr(8'h04, 8'h05);
    remote.send(8'h3c, 1'b1, 1'b1);
    chk_intr(1'b1);
    rd("iid", 8'h08, 32'h06);
    rd("lstat", 8'h14, 32'h65);
    rd("iid", 8'h08, 32'h04);
    chk_intr(1'b1);
    rd("data", 8'h00, 32'h3c);
    rd("iid", 8'h08, 32'h01);
    chk_intr(1'b0);
    wr(8'h04, 8'h00);
  endtask
  task t_break;
    remote.send(8'h00, 1'b0, 1'b0);
    remote.send(8'h5a, 1'b0, 1'b1);
    rd("lstat", 8'h14, 32'h7b);
    rd("data", 8'h00, 32'h5a);
  endtask
  task t_hold;
    fork
      remote.send(8'h77, 1'b0, 1'b1);
      begin
        repeat (300) @(posedge CLOCK);
        rd("data held", 8'h00, 32'h5a);
      end
    join
    rd("data new", 8'h00, 32'h77);
  endtask
  task t_tx;
    for (int n = 0; n < 4; n++) begin
      wr(8'h0c, 8'(n));
      fork
        remote.recv(n + 5, b, s);
        wr(8'h00, 8'h69);
      join
      chk("tx word", {24'h0, b}, {24'h0, 8'h69 & (8'hff >> (3 - n))});
      chk("tx stop", {31'h0, s}, 32'h1);
    end
    repeat (64) @(posedge CLOCK);
    rd("lstat idle", 8'h14, 32'h60);
    chk("txd idle", {31'h0, TXD}, 32'h1);
    wr(8'h04, 8'h02);
    chk_intr(1'b1);
    rd("iid thre", 8'h08, 32'h02);
    rd("iid served", 8'h08, 32'h01);
    chk_intr(1'b0);
    wr(8'h04, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge CLOCK);
    ARST_N <= 1'b1;
    t_reset;
    t_parity_on;
    t_sticky;
    t_irq;
    t_break;
    t_hold;
    t_tx;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    errors++;
    end_sim;
  end
endmodule
